//--- rtl/wdw_pkg.sv
/*
  Constants, register layout and carrier types for the watchdog and
  wake-up controller.
  Assumes a single 100 MHz clock domain and a core that pulses its
  halt and clear-watchdog instruction strobes for one cycle each.
*/
// Contract
// - Halt picks standby mode from idle clock bits
// - Fast-only standby keeps fast clock, stops slow
// - Sleep stops everything except the watchdog
// - Halt sets power-down flag, clears timeout flag
// - Standby entry clears counter; runs only if enabled
// - Standby wakes on port edge, interrupt, overflow
// - Power-up or clear instruction clears power-down flag
// - Standby overflow sets flags, resets pc and sp
// - Per-pin wake enable; resume after halt
// - Disabled or stack-full interrupt resumes after halt
// - Enabled interrupt with stack room gets serviced
// - Flag pending at entry cannot wake device
// - Counter ticks on low-speed rc clock
// - Key 10101 disables, 01010 enables, others reset
// - Key resets to 01010, period to 011
// - Bad key sets key-reset flag bit 0, sw clears
// - Period select picks 2^8 to 2^18 ticks
// - Running overflow resets device, sets timeout flag
// - Bad key, clear, or halt clears the counter
`default_nettype none

package wdw_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] ADDR_CONTROL = 4'h0;  // Watchdog control
  localparam logic [3:0] ADDR_CAUSE   = 4'h1;  // Reset cause flags
  localparam logic [3:0] ADDR_STATUS  = 4'h2;  // Flags and mode
  localparam logic [3:0] ADDR_IDLECLK = 4'h3;  // Idle clock enables
  localparam logic [3:0] ADDR_WAKEEN  = 4'h4;  // Port wake enables

  // ==========================================================
  // Field values
  // ==========================================================
  localparam logic [4:0] KEY_DISABLE   = 5'h15;  // 10101
  localparam logic [4:0] KEY_ENABLE    = 5'h0A;  // 01010
  localparam logic [2:0] PERIOD_RESET  = 3'h3;   // 011
  localparam logic [7:0] CONTROL_RESET = 8'h53;
  localparam int         CNT_W         = 19;     // Holds 2^18

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ          = 100;
  localparam int KEY_DELAY_NS     = 1000;  // Key reset delay
  localparam int KEY_DELAY_CYC    = (KEY_DELAY_NS * CLK_MHZ) / 1000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    RUN, SLEEP, SLOW_ONLY, BOTH_CLK, FAST_ONLY
  } wdw_mode_e;

  typedef struct packed {
    logic [4:0] watchdogKeyField;
    logic [2:0] watchdogPeriodSelect;
  } wdw_ctrl_s;

  typedef struct packed {
    logic       fastClockRun;   // High-speed oscillator on
    logic       slowClockRun;   // Low-speed oscillator on
    logic       cpuHold;        // Execution held at halt
    logic       deviceReset;    // Full device reset pulse
    logic       pcSpReset;      // Program counter and stack reset
    logic       wakeResume;     // Resume after the halt
    logic       wakeService;    // Take interrupt entry on wake
  } wdw_core_s;

  typedef struct packed {
    wdw_ctrl_s             ctrl;
    logic                  keyResetFlag;
    logic                  powerDownFlag;
    logic                  timeoutStatusFlag;
    logic                  fastIdleEn;
    logic                  slowIdleEn;
    logic [7:0]            portaWakeEnable;
    wdw_mode_e             mode;
    logic [CNT_W-1:0]      count;
    logic                  lircPrev;
    logic [7:0]            portaPrev;
    logic                  irqMask;       // Flags pending at entry
    logic                  keyPending;
    logic [15:0]           keyTimer;
    wdw_core_s             core;
    logic [7:0]            rdata;
  } wdw_state_s;

endpackage

`default_nettype wire

//--- rtl/wdw_watchdog_wakeup.sv
/*
  Watchdog timer with power-down and wake-up control.
  Assumes halt and clear-watchdog are one-cycle strobes from the core,
  the low-speed rc clock arrives as a synchronous level, and the core
  reports its own interrupt enable and stack fullness.
*/
`default_nettype none

module wdw_watchdog_wakeup (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  input  wire logic        haltInstr,
  input  wire logic        clearInstr,
  input  wire logic        lircLevel,
  input  wire logic [7:0]  portaIn,
  input  wire logic        irqFlag,
  input  wire logic        irqEnable,
  input  wire logic        stackFull,
  output logic             fastClockRun,
  output logic             slowClockRun,
  output logic             cpuHold,
  output logic             deviceReset,
  output logic             pcSpReset,
  output logic             wakeResume,
  output logic             wakeService,
  output logic             powerDownFlag,
  output logic             timeoutStatusFlag
);

  wdw_pkg::wdw_state_s q, d;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Timeout length for a period code
  function automatic logic [wdw_pkg::CNT_W-1:0] limitOf(
      input logic [2:0] sel);
    logic [wdw_pkg::CNT_W-1:0] one;
    one = {{(wdw_pkg::CNT_W-1){1'b0}}, 1'b1};
    case (sel)
      3'h0:    limitOf = one << 8;
      3'h1:    limitOf = one << 10;
      3'h2:    limitOf = one << 12;
      3'h3:    limitOf = one << 14;
      3'h4:    limitOf = one << 15;
      3'h5:    limitOf = one << 16;
      3'h6:    limitOf = one << 17;
      default: limitOf = one << 18;
    endcase
  endfunction

  // Key decode, used for control register writes
  function automatic logic keyValid(input logic [4:0] k);
    keyValid = (k == wdw_pkg::KEY_DISABLE) ||
               (k == wdw_pkg::KEY_ENABLE);
  endfunction

  logic                      lircTick;
  logic                      wdEnabled;
  logic                      overflow;
  logic                      standby;
  logic [7:0]                portaFall;

  assign lircTick  = lircLevel & ~q.lircPrev;
  assign wdEnabled = (q.ctrl.watchdogKeyField == wdw_pkg::KEY_ENABLE);
  assign overflow  = wdEnabled && lircTick &&
                     (q.count + 1'b1 >= limitOf(q.ctrl.watchdogPeriodSelect));
  assign standby   = (q.mode != wdw_pkg::RUN);
  assign portaFall = q.portaPrev & ~portaIn & q.portaWakeEnable;

  // ==========================================================
  // Next state
  // ==========================================================
  // All control state is computed here and registered below
  always_comb begin
    d = q;
    d.lircPrev  = lircLevel;
    d.portaPrev = portaIn;
    d.core.deviceReset = 1'b0;
    d.core.pcSpReset   = 1'b0;
    d.core.wakeResume  = 1'b0;
    d.core.wakeService = 1'b0;
    d.rdata = 8'h00;

    // Counter runs only while enabled
    if (wdEnabled && lircTick) begin
      d.count = q.count + 1'b1;
    end

    // Register writes
    if (regWrite) begin
      if (regAddr == wdw_pkg::ADDR_CONTROL) begin
        d.ctrl = regWdata;
        if (!keyValid(regWdata[7:3])) begin
          d.count      = '0;
          d.keyPending = 1'b1;
          d.keyTimer   = 16'(wdw_pkg::KEY_DELAY_CYC);
        end
      end else if (regAddr == wdw_pkg::ADDR_CAUSE) begin
        // Only a zero write clears; a one is ignored
        if (!regWdata[0]) begin
          d.keyResetFlag = 1'b0;
        end
      end else if (regAddr == wdw_pkg::ADDR_IDLECLK) begin
        d.fastIdleEn = regWdata[1];
        d.slowIdleEn = regWdata[0];
      end else if (regAddr == wdw_pkg::ADDR_WAKEEN) begin
        d.portaWakeEnable = regWdata;
      end
    end

    // Delayed reset after a bad key
    if (q.keyPending) begin
      if (q.keyTimer <= 16'h0001) begin
        d.keyPending       = 1'b0;
        d.core.deviceReset = 1'b1;
        d.keyResetFlag     = 1'b1;
        d.ctrl             = wdw_pkg::CONTROL_RESET;
        d.count            = '0;
        d.mode             = wdw_pkg::RUN;
      end else begin
        d.keyTimer = q.keyTimer - 16'h0001;
      end
    end

    // Clear-watchdog instruction, only meaningful while running
    if (clearInstr && !standby) begin
      d.count         = '0;
      d.powerDownFlag = 1'b0;
    end

    // Halt entry
    if (haltInstr && !standby) begin
      d.count             = '0;
      d.powerDownFlag     = 1'b1;
      d.timeoutStatusFlag = 1'b0;
      d.irqMask           = irqFlag;
      case ({q.fastIdleEn, q.slowIdleEn})
        2'b00:   d.mode = wdw_pkg::SLEEP;
        2'b01:   d.mode = wdw_pkg::SLOW_ONLY;
        2'b11:   d.mode = wdw_pkg::BOTH_CLK;
        default: d.mode = wdw_pkg::FAST_ONLY;
      endcase
    end else if (standby) begin
      // Wake sources; overflow has priority
      if (overflow) begin
        d.timeoutStatusFlag = 1'b1;
        d.powerDownFlag     = 1'b1;
        d.core.pcSpReset    = 1'b1;
        d.count             = '0;
        d.mode              = wdw_pkg::RUN;
      end else if (|portaFall) begin
        d.core.wakeResume = 1'b1;
        d.mode            = wdw_pkg::RUN;
      end else if (irqFlag && !q.irqMask) begin
        if (irqEnable && !stackFull) begin
          d.core.wakeService = 1'b1;
        end else begin
          d.core.wakeResume  = 1'b1;
        end
        d.mode = wdw_pkg::RUN;
      end
    end else if (overflow) begin
      d.core.deviceReset  = 1'b1;
      d.timeoutStatusFlag = 1'b1;
      d.count             = '0;
    end

    // Clock gating per mode
    case (d.mode)
      wdw_pkg::SLEEP: begin
        d.core.fastClockRun = 1'b0;
        d.core.slowClockRun = 1'b0;
      end
      wdw_pkg::SLOW_ONLY: begin
        d.core.fastClockRun = 1'b0;
        d.core.slowClockRun = 1'b1;
      end
      wdw_pkg::BOTH_CLK: begin
        d.core.fastClockRun = 1'b1;
        d.core.slowClockRun = 1'b1;
      end
      wdw_pkg::FAST_ONLY: begin
        d.core.fastClockRun = 1'b1;
        d.core.slowClockRun = 1'b0;
      end
      default: begin
        d.core.fastClockRun = 1'b1;
        d.core.slowClockRun = 1'b1;
      end
    endcase
    d.core.cpuHold = (d.mode != wdw_pkg::RUN);

    // Register reads, data in the next cycle
    if (regRead) begin
      if (regAddr == wdw_pkg::ADDR_CONTROL) begin
        d.rdata = q.ctrl;
      end else if (regAddr == wdw_pkg::ADDR_CAUSE) begin
        d.rdata = {7'h00, q.keyResetFlag};
      end else if (regAddr == wdw_pkg::ADDR_STATUS) begin
        d.rdata = {3'h0, 3'(q.mode), q.powerDownFlag,
                   q.timeoutStatusFlag};
      end else if (regAddr == wdw_pkg::ADDR_IDLECLK) begin
        d.rdata = {6'h00, q.fastIdleEn, q.slowIdleEn};
      end else if (regAddr == wdw_pkg::ADDR_WAKEEN) begin
        d.rdata = q.portaWakeEnable;
      end else begin
        d.rdata = 8'h00;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Synchronous reset to power-on values
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl.watchdogKeyField     <= wdw_pkg::KEY_ENABLE;
      q.ctrl.watchdogPeriodSelect <= wdw_pkg::PERIOD_RESET;
      q.mode                      <= wdw_pkg::RUN;
      q.core.fastClockRun         <= 1'b1;
      q.core.slowClockRun         <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign regRdata          = q.rdata;
  assign fastClockRun      = q.core.fastClockRun;
  assign slowClockRun      = q.core.slowClockRun;
  assign cpuHold           = q.core.cpuHold;
  assign deviceReset       = q.core.deviceReset;
  assign pcSpReset         = q.core.pcSpReset;
  assign wakeResume        = q.core.wakeResume;
  assign wakeService       = q.core.wakeService;
  assign powerDownFlag     = q.powerDownFlag;
  assign timeoutStatusFlag = q.timeoutStatusFlag;

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence haltTaken;
    haltInstr && !standby && !q.keyPending;
  endsequence

  halt_sets_pd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    haltTaken |=> powerDownFlag && !timeoutStatusFlag && cpuHold)
    else $error("halt did not set flags");

  halt_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    haltTaken ##0 (q.fastIdleEn && !q.slowIdleEn) |=>
      fastClockRun && !slowClockRun)
    else $error("fast-only standby clocks wrong");

  sleep_clocks_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    haltTaken ##0 (!q.fastIdleEn && !q.slowIdleEn) |=>
      !fastClockRun && !slowClockRun)
    else $error("sleep clocks not off");

  halt_clears_cnt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    haltTaken |=> q.count == '0)
    else $error("halt did not clear counter");

  clear_pd_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clearInstr && !standby && !haltInstr && !q.keyPending |=>
      !powerDownFlag && q.count == '0)
    else $error("clear instruction failed");

  stby_ovf_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    standby && overflow && !q.keyPending |=>
      pcSpReset && timeoutStatusFlag && powerDownFlag && !deviceReset)
    else $error("standby overflow handled wrong");

  run_ovf_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !standby && overflow && !haltInstr |=> deviceReset && timeoutStatusFlag)
    else $error("running overflow missed");

  masked_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    standby && q.irqMask && !overflow && !(|portaFall) |=>
      !wakeResume && !wakeService)
    else $error("pending flag woke device");

  key_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(q.keyPending) |-> ##[1:110] (deviceReset && q.keyResetFlag))
    else $error("bad key reset missing");

endmodule

`default_nettype wire

//--- test/wdw_core_model.sv
/*
  Core model: turns bench requests into halt and clear strobes.
  Assumes one clock shared with the controller.
*/
`default_nettype none

module wdw_core_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic doHalt,
  input  wire logic doClear,
  input  wire logic keepAlive,
  input  wire logic cpuHold,
  output logic      haltInstr,
  output logic      clearInstr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Instruction strobes
  // ==========================================================
  logic [6:0] tick_q;  // Software loop position

  // A held core issues no instruction at all
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tick_q     <= 7'h00;
      haltInstr  <= 1'b0;
      clearInstr <= 1'b0;
    end else begin
      tick_q     <= tick_q + 7'h01;
      haltInstr  <= doHalt && !cpuHold;
      // Every 128 cycles, well inside the shortest timeout
      clearInstr <= !cpuHold &&
                    (doClear || (keepAlive && tick_q == 7'h7F));
    end
  end
endmodule

`default_nettype wire

//--- test/tb.sv
/*
  Self-checking bench for the watchdog and wake-up controller.
  Assumes the core model issues the instruction strobes.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  // ==========================================================
  logic       ref_clk, reset_n, regWrite, regRead, lircLevel;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, portaIn;
  logic       irqFlag, irqEnable, stackFull, doHalt, doClear;
  logic       keepAlive, haltInstr, clearInstr, cpuHold;
  logic       fastClockRun, slowClockRun, deviceReset, pcSpReset;
  logic       wakeResume, wakeService, powerDownFlag, timeoutStatusFlag;
  logic [15:0] rnd;   // Random source
  logic [2:0]  pin;   // Wake pin under test
  logic [4:0]  key;   // Invalid key value
  int          error_cnt, check_count, n;

  wdw_watchdog_wakeup u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .haltInstr(haltInstr),
    .clearInstr(clearInstr), .lircLevel(lircLevel),
    .portaIn(portaIn), .irqFlag(irqFlag), .irqEnable(irqEnable),
    .stackFull(stackFull), .fastClockRun(fastClockRun),
    .slowClockRun(slowClockRun), .cpuHold(cpuHold),
    .deviceReset(deviceReset), .pcSpReset(pcSpReset),
    .wakeResume(wakeResume), .wakeService(wakeService),
    .powerDownFlag(powerDownFlag),
    .timeoutStatusFlag(timeoutStatusFlag));

  wdw_core_model u_core (
    .ref_clk(ref_clk), .reset_n(reset_n), .doHalt(doHalt),
    .doClear(doClear), .keepAlive(keepAlive), .cpuHold(cpuHold),
    .haltInstr(haltInstr), .clearInstr(clearInstr));

  // ==========================================================
  // Clocks
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Slow rc clock ticks every second cycle to keep runs short
  always @(posedge ref_clk) lircLevel <= ~lircLevel;

  // ==========================================================
  // Helpers
  // ==========================================================
  function logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function logic sig(input int w);
    case (w)
      0: sig = wakeResume;
      1: sig = wakeService;
      2: sig = deviceReset;
      default: sig = pcSpReset;
    endcase
  endfunction

  // Standby code from {fast, slow} idle bits
  function logic [2:0] modeOf(input logic [1:0] i);
    case (i)
      2'h0: modeOf = wdw_pkg::SLEEP;
      2'h1: modeOf = wdw_pkg::SLOW_ONLY;
      2'h3: modeOf = wdw_pkg::BOTH_CLK;
      default: modeOf = wdw_pkg::FAST_ONLY;
    endcase
  endfunction

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s exp %0h got %0h", nm, e, g);
      error_cnt++;
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(nm, e, regRdata);
  endtask

  // Bounded wait; n tells how many cycles it took
  task waitSig(input int w, input int lim);
    n = 0;
    while (n < lim && sig(w) !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  // Halt or clear through the core model
  task instr(input logic h);
    @(posedge ref_clk);
    doHalt <= h;
    doClear <= !h;
    @(posedge ref_clk);
    doHalt <= 1'b0;
    doClear <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // A disabled pin falls first and must not wake
  task pinWake();
    @(posedge ref_clk);
    portaIn <= ~(8'h01 << (pin + 3'h1));
    waitSig(0, 6);
    chk("offPin", 8'h00, {7'h0, wakeResume});
    @(posedge ref_clk);
    portaIn <= ~(8'h01 << pin);
    waitSig(0, 6);
    chk("pinWake", 8'h01, {7'h0, wakeResume});
    @(posedge ref_clk);
    portaIn <= 8'hFF;
    #1 chk("resume", 8'h00, {7'h0, cpuHold});
  endtask

  task wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {reset_n, regWrite, regRead, lircLevel, doHalt} = 5'h00;
    {irqFlag, irqEnable, stackFull, doClear, keepAlive} = 5'h00;
    regAddr = 4'h0;
    regWdata = 8'h00;
    portaIn = 8'hFF;
    error_cnt = 0;
    check_count = 0;
    rnd = 16'hC78A;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(wdw_pkg::ADDR_CONTROL, wdw_pkg::CONTROL_RESET, "ctrl");
    rd(wdw_pkg::ADDR_CAUSE, 8'h00, "cause");
    rd(4'hF, 8'h00, "unmapped");
    rnd = lfsr(rnd);
    pin = rnd[2:0];
    wr(wdw_pkg::ADDR_WAKEEN, 8'h01 << pin);
    // Every standby mode, woken by a pin, then cleared
    for (int m = 0; m < 4; m++) begin
      wr(wdw_pkg::ADDR_IDLECLK, 8'(m));
      instr(1'b1);
      chk("fast", {7'h0, m[1]}, {7'h0, fastClockRun});
      chk("slow", {7'h0, m[0]}, {7'h0, slowClockRun});
      rd(wdw_pkg::ADDR_STATUS, {3'h0, modeOf(m[1:0]), 2'h2}, "st");
      pinWake();
      instr(1'b0);
      chk("pdClr", 8'h00, {7'h0, powerDownFlag});
    end
    // Interrupt wake: serviced, disabled, stack full
    for (int c = 0; c < 3; c++) begin
      instr(1'b1);
      @(posedge ref_clk);
      irqEnable <= c != 1;
      stackFull <= c == 2;
      irqFlag <= 1'b1;
      waitSig(c == 0 ? 1 : 0, 6);
      chk("irqWake", 8'h01, {7'h0, sig(c == 0 ? 1 : 0)});
      @(posedge ref_clk);
      irqFlag <= 1'b0;
    end
    // A flag already pending cannot wake
    @(posedge ref_clk);
    irqFlag <= 1'b1;
    instr(1'b1);
    waitSig(1, 20);
    chk("pending", 8'h01, {7'h0, cpuHold});
    pinWake();
    @(posedge ref_clk);
    irqFlag <= 1'b0;
    // Disabled watchdog never overflows
    wr(wdw_pkg::ADDR_CONTROL, {wdw_pkg::KEY_DISABLE, 3'h0});
    instr(1'b1);
    waitSig(3, 700);
    chk("offStby", 8'h01, {7'h0, cpuHold});
    pinWake();
    waitSig(2, 700);
    chk("offRun", 8'h00, {7'h0, deviceReset});
    // Shortest period, kept alive, then left to run out
    @(posedge ref_clk);
    keepAlive <= 1'b1;
    wr(wdw_pkg::ADDR_CONTROL, {wdw_pkg::KEY_ENABLE, 3'h0});
    waitSig(2, 1500);
    chk("alive", 8'h00, {7'h0, deviceReset});
    @(posedge ref_clk);
    keepAlive <= 1'b0;
    waitSig(2, 600);
    chk("runOvf", 8'h01, {7'h0, deviceReset});
    chk("ovfTime", 8'h01, {7'h0, n > 370});
    @(posedge ref_clk);
    #1 chk("toFlag", 8'h01, {7'h0, timeoutStatusFlag});
    // Overflow while halted
    wr(wdw_pkg::ADDR_CONTROL, {wdw_pkg::KEY_ENABLE, 3'h0});
    instr(1'b1);
    waitSig(3, 600);
    chk("stbyOvf", 8'h01, {7'h0, pcSpReset});
    chk("noFull", 8'h00, {7'h0, deviceReset});
    @(posedge ref_clk);
    #1 chk("flags", 8'h03, {6'h0, powerDownFlag, timeoutStatusFlag});
    // Invalid key value
    rnd = lfsr(rnd);
    key = rnd[4:0];
    if (key == wdw_pkg::KEY_ENABLE || key == wdw_pkg::KEY_DISABLE) begin
      key = key ^ 5'h01;
    end
    wr(wdw_pkg::ADDR_CONTROL, {key, 3'h3});
    waitSig(2, 120);
    chk("keyRst", 8'h01, {7'h0, deviceReset});
    chk("keyDly", 8'h01, {7'h0, n >= wdw_pkg::KEY_DELAY_CYC - 3});
    rd(wdw_pkg::ADDR_CAUSE, 8'h01, "cause");
    rd(wdw_pkg::ADDR_CONTROL, wdw_pkg::CONTROL_RESET, "ctrl");
    wr(wdw_pkg::ADDR_CAUSE, 8'h01);
    rd(wdw_pkg::ADDR_CAUSE, 8'h01, "causeSet");
    wr(wdw_pkg::ADDR_CAUSE, 8'h00);
    rd(wdw_pkg::ADDR_CAUSE, 8'h00, "causeClr");
    wrap_up();
  end
endmodule

`default_nettype wire
